// file: rtl/clock_select_output_format_regs.sv
// How it works
// - Method field: 00 manual, 01 automatic non-revertive, 10 automatic revertive, 11 reserved.
// - Five-bit history delay field in bits 4:0 drives holdover history building.
// - In CMOS format, two-bit drive field picks strength, 00 weakest to 11 strongest.
// - Sleep bit 6 disables all outputs and powers down; clearing restores operation.
// - During sleep both output decoders ignore their format fields; no code re-enables an output.
// - Output two format bits 5:3 decode disable, CMOS, low-swing LVDS, LVPECL, CML, LVDS.
// - Output one format bits 2:0 use same codes, controlling only output one.
// - Selection and history register resets to 0001 0010.
// - Drive strength register resets to 1110 1101.
// - Manual with pin option set: external pin picks input, register choice ignored.
// - Automatic methods rank inputs by first and second priority fields, 00 input one.
// - Forced holdover overrides manual and automatic selection, ignoring input quality.
`timescale 1ns/1ps
module clock_select_output_format_regs
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic resetn,
    // Register port from the serial configuration front end.
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    output logic regAck,
    // Selection controls held in neighbouring registers.
    input wire logic pinSelectOption,
    input wire logic externalSelectPin,
    input wire logic [1:0] registerInputChoice,
    input wire logic [1:0] firstPriorityInput,
    input wire logic [1:0] secondPriorityInput,
    input wire logic forcedHoldover,
    input wire logic [1:0] inputGood,
    input wire logic bypassMode,
    // Selection results.
    output logic [1:0] inputSelectMethod,
    output logic autoRevertive,
    output logic [4:0] holdoverHistoryDelay,
    output logic [1:0] activeInput,
    output logic holdoverActive,
    // Output buffer controls.
    output logic [1:0] cmosDriveStrength,
    output logic powerDown,
    output logic [4:0] outOneMode,
    output logic outOneEnable,
    output logic [4:0] outTwoMode,
    output logic outTwoEnable,
    output logic bypassCmosConflict
);
    logic [7:0] selHist_r;
    logic [7:0] drive_r;
    logic [7:0] sleepFmt_r;
    logic [1:0] ext_r;
    logic extStable_r;
    logic extLate_r;
    logic [1:0] active_r;

    function automatic logic [7:0] mergeWrite(input logic [7:0] old, input logic [7:0] wd,
                                              input logic [7:0] mask);
        mergeWrite = (wd & mask) | (old & ~mask);
    endfunction

    // Register writes take a whole byte; reserved bits keep their reset value.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            selHist_r <= clk_cfg_pkg::SEL_HIST_RST;
            drive_r <= clk_cfg_pkg::DRIVE_RST;
            sleepFmt_r <= clk_cfg_pkg::SLEEP_FMT_RST;
        end
        else if (regWrite)
        begin
            if (regAddr == clk_cfg_pkg::SEL_HIST_OFS)
            begin
                selHist_r <= mergeWrite(selHist_r, regWdata,
                                        clk_cfg_pkg::SEL_HIST_WMASK);
            end
            else if (regAddr == clk_cfg_pkg::DRIVE_OFS)
            begin
                drive_r <= mergeWrite(drive_r, regWdata, clk_cfg_pkg::DRIVE_WMASK);
            end
            else if (regAddr == clk_cfg_pkg::SLEEP_FMT_OFS)
            begin
                sleepFmt_r <= mergeWrite(sleepFmt_r, regWdata,
                                         clk_cfg_pkg::SLEEP_FMT_WMASK);
            end
        end
    end

    // Read data and acknowledge one cycle after the strobe; unmapped reads return zero.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            regRdata <= 8'h00;
            regAck <= 1'b0;
        end
        else
        begin
            regAck <= regRead | regWrite;
            if (!regRead)
            begin
                regRdata <= regRdata;
            end
            else if (regAddr == clk_cfg_pkg::SEL_HIST_OFS)
            begin
                regRdata <= selHist_r;
            end
            else if (regAddr == clk_cfg_pkg::DRIVE_OFS)
            begin
                regRdata <= drive_r;
            end
            else if (regAddr == clk_cfg_pkg::SLEEP_FMT_OFS)
            begin
                regRdata <= sleepFmt_r;
            end
            else
            begin
                regRdata <= 8'h00;
            end
        end
    end

    // Field outputs, registered so they follow a completed write by one cycle.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            inputSelectMethod <= clk_cfg_pkg::METHOD_MANUAL;
            autoRevertive <= 1'b0;
            holdoverHistoryDelay <= 5'h00;
            cmosDriveStrength <= 2'h0;
            powerDown <= 1'b0;
            bypassCmosConflict <= 1'b0;
        end
        else
        begin
            inputSelectMethod <= selHist_r[clk_cfg_pkg::METHOD_LSB +: 2];
            autoRevertive <= (selHist_r[clk_cfg_pkg::METHOD_LSB +: 2]
                == clk_cfg_pkg::METHOD_REV);
            holdoverHistoryDelay <= selHist_r[clk_cfg_pkg::HIST_LSB +: 5];
            cmosDriveStrength <= drive_r[clk_cfg_pkg::DRIVE_LSB +: 2];
            powerDown <= sleepFmt_r[clk_cfg_pkg::SLEEP_BIT];
            bypassCmosConflict <= bypassMode
                && (sleepFmt_r[clk_cfg_pkg::FMT1_LSB +: 3] == clk_cfg_pkg::FMT_CMOS
                || sleepFmt_r[clk_cfg_pkg::FMT2_LSB +: 3] == clk_cfg_pkg::FMT_CMOS);
        end
    end

    // External select pin: three-stage synchroniser, change taken when stages two and three agree.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ext_r <= 2'h0;
            extLate_r <= 1'b0;
            extStable_r <= 1'b0;
        end
        else
        begin
            ext_r <= {ext_r[0], externalSelectPin};
            extLate_r <= ext_r[1];
            if (ext_r[1] == extLate_r)
            begin
                extStable_r <= extLate_r;
            end
        end
    end

    // Input selection.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            active_r <= 2'h0;
            activeInput <= 2'h0;
            holdoverActive <= 1'b0;
        end
        else
        begin
            holdoverActive <= forcedHoldover;
            activeInput <= active_r;
            if (forcedHoldover)
            begin
                active_r <= active_r;
            end
            else if (selHist_r[clk_cfg_pkg::METHOD_LSB +: 2] == clk_cfg_pkg::METHOD_MANUAL)
            begin
                active_r <= pinSelectOption ? {1'b0, extStable_r} : registerInputChoice;
            end
            else if (selHist_r[clk_cfg_pkg::METHOD_LSB +: 2] == clk_cfg_pkg::METHOD_REV
                     || !inputGood[active_r[0]])
            begin
                if (inputGood[firstPriorityInput[0]])
                begin
                    active_r <= {1'b0, firstPriorityInput[0]};
                end
                else if (inputGood[secondPriorityInput[0]])
                begin
                    active_r <= {1'b0, secondPriorityInput[0]};
                end
            end
        end
    end

    out_format_decode u_out_one
    (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .formatCode(sleepFmt_r[clk_cfg_pkg::FMT1_LSB +: 3]),
        .sleepOn(sleepFmt_r[clk_cfg_pkg::SLEEP_BIT]),
        .bufMode(outOneMode),
        .bufEnable(outOneEnable)
    );

    out_format_decode u_out_two
    (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .formatCode(sleepFmt_r[clk_cfg_pkg::FMT2_LSB +: 3]),
        .sleepOn(sleepFmt_r[clk_cfg_pkg::SLEEP_BIT]),
        .bufMode(outTwoMode),
        .bufEnable(outTwoEnable)
    );
endmodule

// file: rtl/clk_cfg_pkg.sv
package clk_cfg_pkg;
    // Register offsets.
    localparam logic [7:0] SEL_HIST_OFS = 8'h04;
    localparam logic [7:0] DRIVE_OFS = 8'h05;
    localparam logic [7:0] SLEEP_FMT_OFS = 8'h06;
    // Reset values.
    localparam logic [7:0] SEL_HIST_RST = 8'h12;
    localparam logic [7:0] DRIVE_RST = 8'hED;
    localparam logic [7:0] SLEEP_FMT_RST = 8'h3F;
    // Writable bit masks; the remaining bits are reserved and read-only.
    localparam logic [7:0] SEL_HIST_WMASK = 8'hDF;
    localparam logic [7:0] DRIVE_WMASK = 8'hC0;
    localparam logic [7:0] SLEEP_FMT_WMASK = 8'h7F;
    // Field positions.
    localparam int METHOD_LSB = 6;
    localparam int HIST_LSB = 0;
    localparam int DRIVE_LSB = 6;
    localparam int SLEEP_BIT = 6;
    localparam int FMT2_LSB = 3;
    localparam int FMT1_LSB = 0;
    // Selection method codes.
    localparam logic [1:0] METHOD_MANUAL = 2'h0;
    localparam logic [1:0] METHOD_NONREV = 2'h1;
    localparam logic [1:0] METHOD_REV = 2'h2;
    // Output format codes.
    localparam logic [2:0] FMT_DISABLE = 3'h1;
    localparam logic [2:0] FMT_CMOS = 3'h2;
    localparam logic [2:0] FMT_LSLVDS = 3'h3;
    localparam logic [2:0] FMT_LVPECL = 3'h5;
    localparam logic [2:0] FMT_CML = 3'h6;
    localparam logic [2:0] FMT_LVDS = 3'h7;
    // Decoded buffer modes, one-hot: cmos, lslvds, lvpecl, cml, lvds.
    localparam int MODE_W = 5;
    localparam logic [4:0] MODE_OFF = 5'h00;
    localparam logic [4:0] MODE_CMOS = 5'h01;
    localparam logic [4:0] MODE_LSLVDS = 5'h02;
    localparam logic [4:0] MODE_LVPECL = 5'h04;
    localparam logic [4:0] MODE_CML = 5'h08;
    localparam logic [4:0] MODE_LVDS = 5'h10;
endpackage

// file: rtl/out_format_decode.sv
`timescale 1ns/1ps
// Registered decode of one output's format code into buffer controls.
module out_format_decode
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic resetn,
    // Controls.
    input wire logic [2:0] formatCode,
    input wire logic sleepOn,
    // Buffer controls.
    output logic [4:0] bufMode,
    output logic bufEnable
);
    function automatic logic [4:0] decodeFormat(input logic [2:0] code);
        case (code)
            clk_cfg_pkg::FMT_CMOS: decodeFormat = clk_cfg_pkg::MODE_CMOS;
            clk_cfg_pkg::FMT_LSLVDS: decodeFormat = clk_cfg_pkg::MODE_LSLVDS;
            clk_cfg_pkg::FMT_LVPECL: decodeFormat = clk_cfg_pkg::MODE_LVPECL;
            clk_cfg_pkg::FMT_CML: decodeFormat = clk_cfg_pkg::MODE_CML;
            clk_cfg_pkg::FMT_LVDS: decodeFormat = clk_cfg_pkg::MODE_LVDS;
            default: decodeFormat = clk_cfg_pkg::MODE_OFF;
        endcase
    endfunction

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            bufMode <= clk_cfg_pkg::MODE_OFF;
            bufEnable <= 1'b0;
        end
        else if (sleepOn)
        begin
            bufMode <= clk_cfg_pkg::MODE_OFF;
            bufEnable <= 1'b0;
        end
        else
        begin
            bufMode <= decodeFormat(formatCode);
            bufEnable <= (decodeFormat(formatCode) != clk_cfg_pkg::MODE_OFF);
        end
    end
endmodule

// file: sim/clock_select_output_format_regs_asserts.sv
`timescale 1ns/1ps
module clock_select_output_format_regs_asserts
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic resetn,
    // Register port.
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWdata,
    input wire logic regAck,
    // Selection.
    input wire logic forcedHoldover,
    input wire logic [1:0] inputSelectMethod,
    input wire logic autoRevertive,
    input wire logic [4:0] holdoverHistoryDelay,
    input wire logic [1:0] activeInput,
    input wire logic holdoverActive,
    // Buffers.
    input wire logic [1:0] cmosDriveStrength,
    input wire logic powerDown,
    input wire logic [4:0] outOneMode,
    input wire logic outOneEnable,
    input wire logic [4:0] outTwoMode,
    input wire logic outTwoEnable
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    sequence s_wr(logic [7:0] a);
        regWrite && regAddr == a;
    endsequence
    a_ack_follows: assert property ((regWrite || regRead) |=> regAck)
        else $error("ack missing after strobe");
    a_ack_cause: assert property (regAck |-> $past(regWrite || regRead))
        else $error("ack without strobe");
    a_method_update: assert property (s_wr(8'h04) |-> ##2
        inputSelectMethod == $past(regWdata[7:6], 2))
        else $error("method field not updated");
    a_revert_code: assert property (autoRevertive == (inputSelectMethod == 2'h2))
        else $error("revertive flag wrong");
    a_hist_update: assert property (s_wr(8'h04) |-> ##2
        holdoverHistoryDelay == $past(regWdata[4:0], 2))
        else $error("history delay not updated");
    a_drive_update: assert property (s_wr(8'h05) |-> ##2
        cmosDriveStrength == $past(regWdata[7:6], 2))
        else $error("drive field not updated");
    a_sleep_update: assert property (s_wr(8'h06) |-> ##2
        powerDown == $past(regWdata[6], 2))
        else $error("sleep bit not updated");
    a_sleep_quiet: assert property (powerDown && $past(powerDown) |->
        !outOneEnable && !outTwoEnable && outOneMode == 5'h00 && outTwoMode == 5'h00)
        else $error("output on during sleep");
    a_enable_mode: assert property (
        outOneEnable == (outOneMode != 5'h00) && outTwoEnable == (outTwoMode != 5'h00))
        else $error("enable and mode disagree");
    a_hold_freeze: assert property (forcedHoldover [*2] |=> $stable(activeInput))
        else $error("input changed in holdover");
    a_hold_flag: assert property ($past(resetn) |->
        holdoverActive == $past(forcedHoldover))
        else $error("holdover flag wrong");
endmodule
bind clock_select_output_format_regs clock_select_output_format_regs_asserts i_asserts
(
    .clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWdata(regWdata), .regAck(regAck), .forcedHoldover(forcedHoldover),
    .inputSelectMethod(inputSelectMethod), .autoRevertive(autoRevertive),
    .holdoverHistoryDelay(holdoverHistoryDelay), .activeInput(activeInput),
    .holdoverActive(holdoverActive), .cmosDriveStrength(cmosDriveStrength),
    .powerDown(powerDown), .outOneMode(outOneMode), .outOneEnable(outOneEnable),
    .outTwoMode(outTwoMode), .outTwoEnable(outTwoEnable)
);

// file: sim/clock_select_output_format_regs_bench.sv
`timescale 1ns/1ps
module clock_select_output_format_regs_bench;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic pinSelectOption = 1'b0;
    logic externalSelectPin = 1'b0;
    logic forcedHoldover = 1'b0;
    logic bypassMode = 1'b0;
    logic [1:0] registerInputChoice = 2'h0;
    logic [1:0] firstPriorityInput = 2'h0;
    logic [1:0] secondPriorityInput = 2'h1;
    logic [1:0] inputGood = 2'h3;
    logic [7:0] regRdata;
    logic regAck, autoRevertive, holdoverActive, powerDown, outOneEnable, outTwoEnable;
    logic bypassCmosConflict;
    logic [1:0] inputSelectMethod, activeInput, cmosDriveStrength;
    logic [4:0] holdoverHistoryDelay, outOneMode, outTwoMode;
    logic [7:0] rdv;
    logic [7:0] want;
    logic [7:0] rst [3] = '{8'h12, 8'hED, clk_cfg_pkg::SLEEP_FMT_RST};
    logic [7:0] msk [3] = '{8'hDF, 8'hC0, 8'h7F};
    logic [4:0] modeTab [8] = '{5'h00, 5'h00, 5'h01, 5'h02, 5'h00, 5'h04, 5'h08, 5'h10};
    int miscompares = 0;
    int cmp_count = 0;

    clock_select_output_format_regs i_clock_select_output_format_regs
    (
        .clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .regAck(regAck),
        .pinSelectOption(pinSelectOption), .externalSelectPin(externalSelectPin),
        .registerInputChoice(registerInputChoice), .firstPriorityInput(firstPriorityInput),
        .secondPriorityInput(secondPriorityInput), .forcedHoldover(forcedHoldover),
        .inputGood(inputGood), .bypassMode(bypassMode), .inputSelectMethod(inputSelectMethod),
        .autoRevertive(autoRevertive), .holdoverHistoryDelay(holdoverHistoryDelay),
        .activeInput(activeInput), .holdoverActive(holdoverActive),
        .cmosDriveStrength(cmosDriveStrength), .powerDown(powerDown), .outOneMode(outOneMode),
        .outOneEnable(outOneEnable), .outTwoMode(outTwoMode), .outTwoEnable(outTwoEnable),
        .bypassCmosConflict(bypassCmosConflict)
    );

    initial
    begin
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
            miscompares++;
        end
    endtask

    task automatic end_sim;
        if (miscompares == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // One register access; the answer comes exactly one cycle after the strobe.
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regWrite <= wr;
        regRead <= !wr;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWrite <= 1'b0;
        regRead <= 1'b0;
        #1;
        chk("ack", {7'h00, regAck}, 8'h01);
        rdv = regRdata;
    endtask

    task automatic settle;
        repeat (8) @(posedge clk_sys);
        #1;
    endtask

    initial
    begin
        #20000;
        miscompares++;
        end_sim();
    end

    initial
    begin
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            acc(1'b0, 8'h04 + 8'(i), 8'h00);
            chk("reset", rdv, rst[i]);
            acc(1'b1, 8'h04 + 8'(i), 8'hFF);
            acc(1'b0, 8'h04 + 8'(i), 8'h00);
            chk("rsvd", rdv, (rst[i] & ~msk[i]) | msk[i]);
        end
        acc(1'b1, 8'h07, 8'hFF);
        acc(1'b0, 8'h07, 8'h00);
        chk("unmapped", rdv, 8'h00);
        for (int i = 0; i < 3; i++)
        begin
            acc(1'b1, 8'h04, {2'(i), 1'b0, 5'(i * 15)});
            settle();
            chk("method", 8'(inputSelectMethod), 8'(i));
            chk("revert", 8'(autoRevertive), 8'(i == 2));
            chk("hist", 8'(holdoverHistoryDelay), 8'(i * 15));
        end
        for (int d = 0; d < 4; d++)
        begin
            acc(1'b1, 8'h05, {2'(d), 6'h00});
            settle();
            chk("drive", 8'(cmosDriveStrength), 8'(d));
        end
        for (int c = 0; c < 8; c++)
        begin
            want = {modeTab[c] != 5'h00, 2'h0, modeTab[c]};
            acc(1'b1, 8'h06, {2'h0, 3'(c), 3'h1});
            settle();
            chk("two", {outTwoEnable, 2'h0, outTwoMode}, want);
            chk("one off", {outOneEnable, 2'h0, outOneMode}, 8'h00);
            acc(1'b1, 8'h06, {2'h0, 3'h1, 3'(c)});
            settle();
            chk("one", {outOneEnable, 2'h0, outOneMode}, want);
            chk("two off", {outTwoEnable, 2'h0, outTwoMode}, 8'h00);
        end
        acc(1'b1, 8'h06, 8'h52);
        settle();
        chk("sleep", {powerDown, outOneEnable, outTwoEnable, outOneMode}, 8'h80);
        acc(1'b1, 8'h06, 8'h3F);
        settle();
        chk("wake", {powerDown, outOneEnable, outTwoEnable, outTwoMode}, 8'h70);
        @(posedge clk_sys);
        bypassMode <= 1'b1;
        acc(1'b1, 8'h06, 8'h17);
        settle();
        chk("bypass", 8'(bypassCmosConflict), 8'h01);
        acc(1'b1, 8'h04, 8'h00);
        @(posedge clk_sys);
        bypassMode <= 1'b0;
        pinSelectOption <= 1'b1;
        registerInputChoice <= 2'h1;
        externalSelectPin <= 1'b1;
        settle();
        chk("pin", 8'(activeInput), 8'h01);
        @(posedge clk_sys);
        externalSelectPin <= 1'b0;
        settle();
        chk("pin", 8'(activeInput), 8'h00);
        @(posedge clk_sys);
        pinSelectOption <= 1'b0;
        settle();
        chk("reg", 8'(activeInput), 8'h01);
        acc(1'b1, 8'h04, 8'h80);
        @(posedge clk_sys);
        firstPriorityInput <= 2'h1;
        secondPriorityInput <= 2'h0;
        settle();
        chk("prio", 8'(activeInput), 8'h01);
        @(posedge clk_sys);
        inputGood <= 2'h1;
        settle();
        chk("fail", 8'(activeInput), 8'h00);
        @(posedge clk_sys);
        inputGood <= 2'h3;
        forcedHoldover <= 1'b1;
        settle();
        chk("hold", {holdoverActive, 5'h00, activeInput}, 8'h80);
        // Non-revertive: keep the current input while it is good, move only when it fails.
        acc(1'b1, 8'h04, 8'h40);
        @(posedge clk_sys);
        forcedHoldover <= 1'b0;
        settle();
        chk("nonrev", 8'(activeInput), 8'h00);
        @(posedge clk_sys);
        inputGood <= 2'h2;
        settle();
        chk("switch", 8'(activeInput), 8'h01);
        @(posedge clk_sys);
        inputGood <= 2'h3;
        firstPriorityInput <= 2'h0;
        secondPriorityInput <= 2'h1;
        settle();
        chk("stay", 8'(activeInput), 8'h01);
        // A reset in mid-run must bring back the reset values.
        @(posedge clk_sys);
        resetn <= 1'b0;
        @(posedge clk_sys);
        resetn <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            acc(1'b0, 8'h04 + 8'(i), 8'h00);
            chk("rereset", rdv, rst[i]);
        end
        end_sim();
    end
endmodule
